// file: logic/xba_pkg.sv
// package for the external bus hold arbiter: modes, states, carriers
// assumes a single 250 MHz clock domain and no software register access
package xba_pkg;

  localparam int unsigned XBA_CLK_MHZ = 250;
  localparam int unsigned XBA_SYNC_STAGES = 2;
  // bus_request_out handshake spacing in ns, then in clock cycles
  localparam int unsigned XBA_BUS_REQUEST_OUT_GAP_NS = 4;
  localparam int unsigned XBA_BUS_REQUEST_OUT_GAP_CYC =
    (XBA_BUS_REQUEST_OUT_GAP_NS * XBA_CLK_MHZ + 999) / 1000;
  localparam int unsigned XBA_MODE_W = 2;

  localparam logic [1:0] XBA_MODE_OFF = 2'h0;
  localparam logic [1:0] XBA_MODE_MASTER = 2'h1;
  localparam logic [1:0] XBA_MODE_SLAVE = 2'h2;
  localparam logic [1:0] XBA_MODE_ALONE = 2'h3;
  localparam logic [1:0] XBA_MODE_RESET = XBA_MODE_MASTER;

  typedef enum logic [2:0] {
    XBA_OWN,      // we own the external bus
    XBA_DRAIN,    // finishing current access before backing off
    XBA_HOLD,     // bus released, partner owns it
    XBA_REQ,      // slave side waiting for acknowledge low
    XBA_RESUME    // acknowledge raised, bus not yet driven
  } xba_state_e;

  // arbitration wires as seen by this device
  typedef struct packed {
    logic hold_n;
    logic hold_acknowledge;
  } xba_arb_in_s;

  // internal request side toward the bus engine
  typedef struct packed {
    logic grant;
    logic error;
    logic drive_en;
  } xba_core_s;

endpackage

// file: logic/xba_arbiter.sv
// external bus hold arbiter of the external bus controller
// assumes: partner on an unrelated clock; access_busy_i from own engine
`timescale 1ns/10ps

module xba_arbiter (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [xba_pkg::XBA_MODE_W-1:0] arbitration_mode_field_i,
  input wire logic ext_req_i,
  input wire logic access_busy_i,
  input wire logic hold_n_i,
  input wire logic hold_acknowledge_i,
  output logic hold_acknowledge_o,
  output logic hold_acknowledge_oe_o,
  output logic bus_request_out_n_o,
  output logic ext_grant_o,
  output logic ext_error_o,
  output logic bus_drive_en_o,
  output logic in_hold_o
);
  import xba_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers; partner may run on any clock
  xba_arb_in_s sync1_q;
  xba_arb_in_s sync2_q;
  xba_arb_in_s prev_q;
  xba_arb_in_s pin_in;

  assign pin_in = '{hold_n: hold_n_i, hold_acknowledge: hold_acknowledge_i};

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_q <= '1;
      sync2_q <= '1;
      prev_q <= '1;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  wire hold_fall = prev_q.hold_n & ~sync2_q.hold_n;
  wire hold_high = sync2_q.hold_n;
  wire ack_fall = prev_q.hold_acknowledge & ~sync2_q.hold_acknowledge;
  wire ack_high = sync2_q.hold_acknowledge;

  ////////////////////////////////////////////////////////////////////////
  // mode decode
  wire mode_off = arbitration_mode_field_i == XBA_MODE_OFF;
  wire mode_mst = arbitration_mode_field_i == XBA_MODE_MASTER;
  wire mode_slv = arbitration_mode_field_i == XBA_MODE_SLAVE;
  wire mode_alone = arbitration_mode_field_i == XBA_MODE_ALONE;

  ////////////////////////////////////////////////////////////////////////
  // state machine
  xba_state_e state_q;
  xba_state_e state_d;
  logic did_cycle_q;
  logic did_cycle_d;
  logic ack_out_q;
  logic ack_out_d;
  logic bus_request_out_n_q;
  logic bus_request_out_n_d;
  logic [1:0] gap_q;
  logic [1:0] gap_d;
  logic grant_q;
  logic error_q;
  logic drive_q;

  wire owning = state_q == XBA_OWN || state_q == XBA_DRAIN;
  // a cycle counts once an access has run while we own the bus
  wire cycle_done = did_cycle_q && !access_busy_i;

  always_comb begin
    state_d = state_q;
    did_cycle_d = did_cycle_q;
    ack_out_d = ack_out_q;
    bus_request_out_n_d = bus_request_out_n_q;
    gap_d = gap_q;
    if (gap_q != 2'h0) begin
      gap_d = gap_q - 2'h1;
    end
    if (mode_off || mode_alone) begin
      // arbitration wires ignored; state stays own, but the bus is driven in stand-alone mode only
      state_d = XBA_OWN;
      ack_out_d = 1'b1;
      bus_request_out_n_d = 1'b1;
      did_cycle_d = 1'b0;
    end else if (mode_mst) begin
      unique case (state_q)
        XBA_OWN: begin
          bus_request_out_n_d = 1'b1;
          if (!hold_high) begin
            state_d = XBA_DRAIN;
          end
        end
        XBA_DRAIN: begin
          // finish ongoing transfer before backing off
          if (!access_busy_i) begin
            state_d = XBA_HOLD;
            ack_out_d = 1'b0;
            gap_d = 2'(XBA_BUS_REQUEST_OUT_GAP_CYC);
          end else if (hold_high) begin
            state_d = XBA_OWN;
          end
        end
        XBA_HOLD: begin
          if (ext_req_i && gap_q == 2'h0 && !ack_out_q) begin
            bus_request_out_n_d = 1'b0;
          end
          if (hold_high) begin
            ack_out_d = 1'b1;
            state_d = XBA_RESUME;
          end
        end
        XBA_RESUME: begin
          // acknowledge is high now; take bus and drop request on the same next edge
          state_d = XBA_OWN;
          bus_request_out_n_d = 1'b1;
        end
        default: begin
          state_d = XBA_OWN;
        end
      endcase
    end else begin
      unique case (state_q)
        XBA_HOLD: begin
          // both wires high: stay off the bus
          bus_request_out_n_d = 1'b1;
          // wait until the owner has raised its own request
          if (ext_req_i && hold_high) begin
            bus_request_out_n_d = 1'b0;
            state_d = XBA_REQ;
          end
        end
        XBA_REQ: begin
          if (ack_fall || !ack_high) begin
            state_d = XBA_OWN;
            did_cycle_d = 1'b0;
          end
        end
        XBA_OWN: begin
          if (access_busy_i) begin
            did_cycle_d = 1'b1;
          end
          if (hold_high && ack_high) begin
            // owner never granted the bus: back off at once
            state_d = XBA_HOLD;
          end else if (!hold_high && cycle_done) begin
            // owner request honoured after one full access, or at once when we have no need and are idle
            state_d = XBA_DRAIN;
          end else if (!ext_req_i && !access_busy_i && !hold_high) begin
            state_d = XBA_DRAIN;
          end
        end
        XBA_DRAIN: begin
          if (!access_busy_i) begin
            state_d = XBA_HOLD;
            bus_request_out_n_d = 1'b1;
          end
        end
        default: begin
          state_d = XBA_HOLD;
        end
      endcase
    end
  end

  // slave mode reaching own while hold still low without any need
  // would deadlock, so it drains once idle (trade-off above)

  ////////////////////////////////////////////////////////////////////////
  // outputs
  wire grant_d = (mode_alone || (!mode_off && owning)) && ext_req_i;
  wire error_d = mode_off && ext_req_i;
  wire drive_d = !mode_off && (state_d == XBA_OWN || state_d == XBA_DRAIN);

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= XBA_OWN;
      did_cycle_q <= 1'b0;
      ack_out_q <= 1'b1;
      bus_request_out_n_q <= 1'b1;
      gap_q <= 2'h0;
      grant_q <= 1'b0;
      error_q <= 1'b0;
      drive_q <= 1'b1;
    end else begin
      state_q <= state_d;
      did_cycle_q <= did_cycle_d;
      ack_out_q <= ack_out_d;
      bus_request_out_n_q <= bus_request_out_n_d;
      gap_q <= gap_d;
      grant_q <= grant_d;
      error_q <= error_d;
      drive_q <= drive_d;
    end
  end

  logic ack_oe_q;
  logic hold_flag_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_oe_q <= 1'b1;
      hold_flag_q <= 1'b0;
    end else begin
      ack_oe_q <= mode_mst; // acknowledge is an input in slave mode
      hold_flag_q <= state_d == XBA_HOLD || state_d == XBA_REQ;
    end
  end

  assign hold_acknowledge_o = ack_out_q;
  assign hold_acknowledge_oe_o = ack_oe_q;
  assign bus_request_out_n_o = bus_request_out_n_q;
  assign ext_grant_o = grant_q;
  assign ext_error_o = error_q;
  assign bus_drive_en_o = drive_q;
  assign in_hold_o = hold_flag_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_off_error;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      mode_off && ext_req_i |=> ext_error_o && !ext_grant_o;
  endproperty
  a_off_error: assert property (p_off_error)
    else $error("off mode access not refused");

  property p_alone_grant;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      mode_alone && ext_req_i |=> ext_grant_o;
  endproperty
  a_alone_grant: assert property (p_alone_grant)
    else $error("stand-alone access not granted");

  property p_ack_after_release;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      mode_mst && $fell(hold_acknowledge_o) |-> !bus_drive_en_o;
  endproperty
  a_ack_after_release: assert property (p_ack_after_release)
    else $error("acknowledge low while still driving");

  property p_ack_before_drive;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      mode_mst && $rose(hold_acknowledge_o) |-> !bus_drive_en_o;
  endproperty
  a_ack_before_drive: assert property (p_ack_before_drive)
    else $error("bus driven before acknowledge high");

  property p_bus_request_out_gap;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      mode_mst && $fell(hold_acknowledge_o) |-> bus_request_out_n_o;
  endproperty
  a_bus_request_out_gap: assert property (p_bus_request_out_gap)
    else $error("request dropped with acknowledge");

  property p_bus_request_out_release;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      mode_mst && $rose(hold_acknowledge_o) && !bus_request_out_n_o
      |=> bus_request_out_n_o;
  endproperty
  a_bus_request_out_release: assert property (p_bus_request_out_release)
    else $error("request not raised one cycle after acknowledge");

  property p_slave_hold_tristate;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      mode_slv && state_q == XBA_HOLD |-> !bus_drive_en_o;
  endproperty
  a_slave_hold_tristate: assert property (p_slave_hold_tristate)
    else $error("slave drives bus in hold");

  property p_slave_bus_request_out_release;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      mode_slv && $rose(bus_request_out_n_o) |-> !bus_drive_en_o;
  endproperty
  a_slave_bus_request_out_release: assert property (p_slave_bus_request_out_release)
    else $error("request raised before tristate");

  property p_hold_drain;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      mode_mst && hold_fall && state_q == XBA_OWN |=> state_q == XBA_DRAIN;
  endproperty
  a_hold_drain: assert property (p_hold_drain)
    else $error("hold request not taken in master mode");

  property p_bus_request_out_early;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      mode_mst && $fell(bus_request_out_n_o) |-> !$past(hold_acknowledge_o);
  endproperty
  a_bus_request_out_early: assert property (p_bus_request_out_early)
    else $error("request lowered too soon after acknowledge");

  property p_slave_need;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      mode_slv && $fell(bus_request_out_n_o) |-> $past(ext_req_i);
  endproperty
  a_slave_need: assert property (p_slave_need)
    else $error("slave requested bus without a pending transfer");

  property p_slave_wait_owner;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      mode_slv && $fell(bus_request_out_n_o) |-> $past(hold_high);
  endproperty
  a_slave_wait_owner: assert property (p_slave_wait_owner)
    else $error("slave requested before owner released its request");

  property p_slave_take;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      mode_slv && state_q == XBA_REQ && !ack_high |=> bus_drive_en_o;
  endproperty
  a_slave_take: assert property (p_slave_take)
    else $error("slave did not take the bus after acknowledge");

  property p_slave_keep;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      mode_slv && state_q == XBA_OWN && access_busy_i && !ack_high
      |=> bus_drive_en_o;
  endproperty
  a_slave_keep: assert property (p_slave_keep)
    else $error("slave left the bus during its own access");

  property p_slave_idle;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      mode_slv && state_q == XBA_HOLD && !ext_req_i |=> bus_request_out_n_o;
  endproperty
  a_slave_idle: assert property (p_slave_idle)
    else $error("slave request low with no external need");

endmodule // xba_arbiter

// file: tb/xba_partner.sv
// second bus master facing the arbiter on the three arbitration wires
// assumes: role 0 = requester (partner in slave mode), 1 = default owner
`timescale 1ns/10ps

module xba_partner (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic role_i,
  input wire logic want_i,
  input wire logic peer_ack_i,
  input wire logic peer_bus_request_out_n_i,
  output logic hold_n_o,
  output logic ack_o,
  output logic drv_o
);
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_n_o <= 1'b1;
      ack_o <= 1'b1;
      drv_o <= 1'b0;
    end else if (!role_i) begin
      // new request only once the owner has raised its request again
      if (hold_n_o && want_i && peer_ack_i && peer_bus_request_out_n_i) begin
        hold_n_o <= 1'b0;
      end else if (!hold_n_o && !want_i && !drv_o) begin
        hold_n_o <= 1'b1;
      end
      drv_o <= !hold_n_o && !peer_ack_i && want_i;
      ack_o <= 1'b1;
    end else begin
      // owner backs off the bus before acknowledging, never together
      if (!peer_bus_request_out_n_i && !drv_o) begin
        ack_o <= 1'b0;
      end else if (peer_bus_request_out_n_i) begin
        ack_o <= 1'b1;
      end
      drv_o <= peer_bus_request_out_n_i && ack_o;
      hold_n_o <= !want_i;
    end
  end
endmodule // xba_partner

// file: tb/xba_arbiter_test.sv
// self-checking bench for the hold arbiter with a partner master
// assumes: one 250 MHz clock; partner steered by want and role
`timescale 1ns/10ps

module xba_arbiter_test;
  import xba_pkg::*;
  typedef struct packed {
    logic [1:0] mode;
    logic req;
    logic want;
    logic grant;
    logic err;
  } xba_row_s;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] mode = XBA_MODE_MASTER;
  logic req = 1'b0;
  logic busy = 1'b0;
  logic want = 1'b0;
  logic role = 1'b0;
  logic mon_en = 1'b0;
  logic ack_o, ack_oe, bus_request_out_n, grant, err, bus_en, in_hold;
  logic p_hold_n, p_ack, p_drv;
  int n_fail = 0;
  int compares = 0;
  xba_row_s rows [4];
  wire ack_w = ack_oe ? ack_o : p_ack;
  wire [5:0] obs = {err, grant, in_hold, bus_en, bus_request_out_n, ack_w};
  always #2 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////
  xba_arbiter i_dut (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
    .arbitration_mode_field_i(mode), .ext_req_i(req),
    .access_busy_i(busy), .hold_n_i(p_hold_n),
    .hold_acknowledge_i(ack_w), .hold_acknowledge_o(ack_o),
    .hold_acknowledge_oe_o(ack_oe), .bus_request_out_n_o(bus_request_out_n),
    .ext_grant_o(grant), .ext_error_o(err), .bus_drive_en_o(bus_en),
    .in_hold_o(in_hold));
  xba_partner i_peer (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
    .role_i(role), .want_i(want), .peer_ack_i(ack_w),
    .peer_bus_request_out_n_i(bus_request_out_n), .hold_n_o(p_hold_n), .ack_o(p_ack),
    .drv_o(p_drv));
  ////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic e, input logic s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %b seen %b", nm, e, s);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // bounded wait; a stuck output counts as a mismatch
  task wt(input int i, input logic v);
    int k;
    k = 0;
    while (obs[i] !== v && k < 100) begin
      tick(1);
      k++;
    end
    if (k == 100) chk("wait", v, obs[i]);
  endtask
  task do_reset();
    @(posedge ref_clk) rst_b <= 1'b0;
    mon_en <= 1'b0;
    tick(4);
    @(posedge ref_clk) rst_b <= 1'b1;
    tick(1);
  endtask
  task test_done();
    if (n_fail == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // the two masters must never drive the bus in the same cycle
  always @(posedge ref_clk) if (mon_en && bus_en && p_drv)
    chk("collision", 1'b0, 1'b1);
  initial begin
    #80000;
    n_fail++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rows[0] = {XBA_MODE_OFF, 1'b1, 1'b0, 1'b0, 1'b1};
    rows[1] = {XBA_MODE_MASTER, 1'b1, 1'b0, 1'b1, 1'b0};
    rows[2] = {XBA_MODE_MASTER, 1'b0, 1'b0, 1'b0, 1'b0};
    rows[3] = {XBA_MODE_ALONE, 1'b1, 1'b1, 1'b1, 1'b0};
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    tick(1);
    chk("ack", 1'b1, ack_w);
    chk("ack_oe", 1'b1, ack_oe);
    chk("bus_request_out_n", 1'b1, bus_request_out_n);
    chk("drive_en", 1'b1, bus_en);
    chk("in_hold", 1'b0, in_hold);
    foreach (rows[i]) begin
      @(posedge ref_clk);
      mode <= rows[i].mode;
      req <= rows[i].req;
      want <= rows[i].want;
      tick(8);
      chk("grant", rows[i].grant, grant);
      chk("error", rows[i].err, err);
    end
    // master side: partner asks while our access is still running
    @(posedge ref_clk) {mode, req, want, busy} <= {XBA_MODE_MASTER, 3'b010};
    do_reset();
    @(posedge ref_clk) {want, busy, mon_en} <= 3'b111;
    tick(10);
    chk("ack", 1'b1, ack_w);
    @(posedge ref_clk) busy <= 1'b0;
    wt(0, 1'b0);
    chk("drive_en", 1'b0, bus_en);
    chk("in_hold", 1'b1, in_hold);
    chk("bus_request_out_n", 1'b1, bus_request_out_n);
    @(posedge ref_clk) req <= 1'b1;
    wt(1, 1'b0);
    @(posedge ref_clk) want <= 1'b0;
    wt(0, 1'b1);
    chk("drive_en", 1'b0, bus_en);
    chk("bus_request_out_n", 1'b0, bus_request_out_n);
    tick(1);
    chk("drive_en", 1'b1, bus_en);
    chk("bus_request_out_n", 1'b1, bus_request_out_n);
    chk("in_hold", 1'b0, in_hold);
    // slave side: partner owns the bus, we borrow it twice
    @(posedge ref_clk) {req, role, mode} <= {2'b01, XBA_MODE_SLAVE};
    mon_en <= 1'b0;
    tick(10);
    @(posedge ref_clk) mon_en <= 1'b1;
    tick(10);
    chk("drive_en", 1'b0, bus_en);
    chk("in_hold", 1'b1, in_hold);
    chk("bus_request_out_n", 1'b1, bus_request_out_n);
    @(posedge ref_clk) req <= 1'b1;
    wt(1, 1'b0);
    wt(2, 1'b1);
    chk("ack", 1'b0, ack_w);
    @(posedge ref_clk) {busy, want} <= 2'b11;
    tick(10);
    chk("drive_en", 1'b1, bus_en);
    chk("bus_request_out_n", 1'b0, bus_request_out_n);
    @(posedge ref_clk) {busy, req} <= 2'b00;
    wt(1, 1'b1);
    chk("drive_en", 1'b0, bus_en);
    tick(6);
    chk("in_hold", 1'b1, in_hold);
    // owner still wants the bus: our new need must wait for it
    @(posedge ref_clk) req <= 1'b1;
    tick(8);
    chk("bus_request_out_n", 1'b1, bus_request_out_n);
    @(posedge ref_clk) want <= 1'b0;
    wt(1, 1'b0);
    wt(2, 1'b1);
    chk("in_hold", 1'b0, in_hold);
    test_done();
  end
endmodule // xba_arbiter_test
